// [tb.sv]
// Testbench for the control endpoint output and address block
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    localparam uea_pkg::uea_tok_t O = uea_pkg::TOK_OUT;
    localparam uea_pkg::uea_tok_t I = uea_pkg::TOK_IN;
    localparam uea_pkg::uea_tok_t S = uea_pkg::TOK_SETUP;
    localparam uea_pkg::uea_hs_t  ACK = uea_pkg::HS_ACK;
    localparam uea_pkg::uea_hs_t  NAK = uea_pkg::HS_NAK;
    localparam uea_pkg::uea_hs_t  STL = uea_pkg::HS_STALL;
    logic              clk_i = 1'b0, arst_n_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
    logic [15:0]       reg_addr_i = 16'h0000;
    logic [7:0]        reg_wdata_i = 8'h00, reg_rdata_o, data_byte_i, buf_data_o;
    logic              irq_o, tok_valid_i, data_valid_i, data_pid_i, pkt_end_i, pkt_ok_i;
    logic              hs_valid_o, in_force_nak_o, buf_we_o, buf_setup_o, hv, es;
    uea_pkg::uea_tok_t tok_kind_i;
    uea_pkg::uea_hs_t  hs_code_o, hc;
    logic [6:0]        tok_addr_i;
    logic [3:0]        tok_ep_i;
    logic [2:0]        buf_addr_o;
    int                fail_count = 0, n_tests = 0, nb = 0;

    uea_ep0_out uea_ep0_out_i (.clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
        .reg_rdata_o, .irq_o, .tok_valid_i, .tok_kind_i, .tok_addr_i, .tok_ep_i, .data_valid_i,
        .data_byte_i, .data_pid_i, .pkt_end_i, .pkt_ok_i, .hs_valid_o, .hs_code_o, .in_force_nak_o,
        .buf_we_o, .buf_addr_o, .buf_data_o, .buf_setup_o);
    uea_host_model uea_host_model_i (.clk_i, .hs_valid_i(hs_valid_o), .hs_code_i(hs_code_o),
        .tok_valid_o(tok_valid_i), .tok_kind_o(tok_kind_i), .tok_addr_o(tok_addr_i),
        .tok_ep_o(tok_ep_i), .data_valid_o(data_valid_i), .data_byte_o(data_byte_i),
        .data_pid_o(data_pid_i), .pkt_end_o(pkt_end_i), .pkt_ok_o(pkt_ok_i));

    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_we_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        reg_re_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        @(negedge clk_i);
        `CHK(reg_rdata_o, e)
        @(posedge clk_i);
    endtask : rd

    // One transfer; eb below zero skips the buffer count
    task automatic tx(input uea_pkg::uea_tok_t k, input logic [6:0] a, input int n, input logic p,
                      input logic ok, input logic ev, input uea_pkg::uea_hs_t ec, input int eb);
        nb = 0;
        es = (k == S);
        uea_host_model_i.xfer(k, a, n, p, ok, hv, hc);
        `CHK(hv, ev)
        if (ev)
            `CHK(hc, ec)
        if (eb >= 0)
            `CHK(nb, eb)
    endtask : tx

    task automatic wrap_up;
        $display("Mismatches %0d, comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // Buffer bytes in order, from index zero
    always @(posedge clk_i)
        if (buf_we_o === 1'b1)
        begin
            `CHK(buf_addr_o, 3'(nb))
            `CHK(buf_data_o, 8'(8'hA0 + nb))
            `CHK(buf_setup_o, es)
            nb++;
        end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        wrap_up();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(16'hFF82, 8'h00);
        rd(16'hFF83, 8'h80);
        rd(16'hFFFF, 8'h00);
        rd(16'hFF84, 8'h00);
        rd(16'hFF90, 8'h00);
        wr(16'hFF83, 8'h0F);
        rd(16'hFF83, 8'h00);
        tx(O, 7'h00, 2, 1'b0, 1'b1, 1'b1, NAK, 0);
        wr(16'hFFFF, 8'hFF);
        rd(16'hFFFF, 8'h7F);
        wr(16'hFFFF, 8'h05);
        tx(O, 7'h00, 1, 1'b0, 1'b1, 1'b0, NAK, 0);
        wr(16'hFF85, 8'h02);
        wr(16'hFF82, 8'h84);
        tx(S, 7'h05, 8, 1'b0, 1'b1, 1'b1, ACK, 8);
        `CHK(in_force_nak_o, 1'b1)
        `CHK(irq_o, 1'b1)
        rd(16'hFF82, 8'hA4);
        rd(16'hFF83, 8'h00);
        tx(O, 7'h05, 1, 1'b1, 1'b1, 1'b1, NAK, 0);
        tx(I, 7'h05, 0, 1'b0, 1'b1, 1'b0, NAK, 0);
        `CHK(in_force_nak_o, 1'b1)
        wr(16'hFF85, 8'h00);
        `CHK(irq_o, 1'b0)
        wr(16'hFF85, 8'h02);
        `CHK(irq_o, 1'b1)
        wr(16'hFF84, 8'h02);
        `CHK(irq_o, 1'b0)
        `CHK(in_force_nak_o, 1'b0)
        tx(O, 7'h05, 3, 1'b1, 1'b1, 1'b1, ACK, 3);
        rd(16'hFF83, 8'h83);
        rd(16'hFF82, 8'h84);
        rd(16'hFF84, 8'h01);
        tx(O, 7'h05, 2, 1'b0, 1'b1, 1'b1, NAK, 0);
        wr(16'hFF83, 8'h00);
        tx(O, 7'h05, 10, 1'b0, 1'b1, 1'b1, ACK, 8);
        rd(16'hFF83, 8'h88);
        wr(16'hFF83, 8'h00);
        tx(O, 7'h05, 2, 1'b1, 1'b0, 1'b0, NAK, -1);
        rd(16'hFF83, 8'h08);
        wr(16'hFF82, 8'h8C);
        tx(O, 7'h05, 1, 1'b1, 1'b1, 1'b1, STL, -1);
        rd(16'hFF84, 8'h05);
        tx(S, 7'h05, 8, 1'b0, 1'b1, 1'b1, ACK, 8);
        rd(16'hFF82, 8'hA4);
        // Repeated DATA0 after setup: acknowledged, count and toggle kept
        wr(16'hFF84, 8'h02);
        tx(O, 7'h05, 1, 1'b0, 1'b1, 1'b1, ACK, 1);
        rd(16'hFF83, 8'h08);
        rd(16'hFF82, 8'hA4);
        wrap_up();
    end
endmodule : tb

// [uea_addr_match.sv]
// Token filter: function address and control endpoint match
`timescale 1ns/1ns
module uea_addr_match #(
    parameter int ADDR_W = 7
) (
    input  wire logic              tok_valid_i,  // Token strobe
    input  wire logic [ADDR_W-1:0] tok_addr_i,   // Token address
    input  wire logic [3:0]        tok_ep_i,     // Token endpoint
    input  wire logic [ADDR_W-1:0] own_addr_i,   // Assigned address
    output      logic              hit_o         // Token is ours, endpoint 0
);

    assign hit_o = tok_valid_i && (tok_addr_i == own_addr_i) && (tok_ep_i == uea_pkg::EP0_ENDPOINT);

endmodule : uea_addr_match

// [uea_byte_counter.sv]
// Saturating received byte counter
`timescale 1ns/1ns
module uea_byte_counter #(
    parameter int MAX_BYTES = uea_pkg::EP0_MAX_BYTES
) (
    input  wire logic       clk_i,    // Core clock
    input  wire logic       rst_n_i,  // Synchronised reset, low active
    input  wire logic       clear_i,  // Restart count
    input  wire logic       inc_i,    // One byte taken
    output      logic [3:0] count_o,  // Bytes taken so far
    output      logic       full_o    // Count reached maximum
);

    typedef struct packed {
        logic [3:0] count;
    } uea_cnt_state_t;

    localparam logic [3:0] MAX_CNT = 4'(MAX_BYTES);

    uea_cnt_state_t q;
    uea_cnt_state_t d;

    always_comb
    begin
        d = q;
        if (clear_i)
        begin
            d.count = 4'h0;
        end
        else if (inc_i && (q.count < MAX_CNT))
        begin
            d.count = q.count + 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign count_o = q.count;
    assign full_o  = (q.count >= MAX_CNT);

endmodule : uea_byte_counter

// [uea_ep0_out.sv]
// Control endpoint output direction, function address and event interrupt
//
// Function
// - Firmware-set stall makes OUT answered with STALL; hardware clears it later.
// - Stall bit clears itself when the next SETUP data packet ends with good CRC.
// - Config bit 5 shows the expected DATA0/DATA1 toggle state.
// - OUT buffer writes to this endpoint only while permit bit 7 is high; SETUP data is written regardless of permit.
// - Byte count bits 3:0 read-only, 0 to 8, never codes above eight.
// - Setup-received flag set forces NAK on IN and, unless stall is set, on OUT of endpoint 0.
// - Seven-bit function address, reset zero; only matching tokens answered.
`timescale 1ns/1ns
module uea_ep0_out #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input  wire logic                clk_i,          // Core clock, 50 MHz
    input  wire logic                arst_n_i,       // Asynchronous reset, low active
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr_i,     // Register address
    input  wire logic [DATA_W-1:0]   reg_wdata_i,    // Write data
    input  wire logic                reg_we_i,       // Write strobe
    input  wire logic                reg_re_i,       // Read strobe
    output      logic [DATA_W-1:0]   reg_rdata_o,    // Read data, cycle after strobe
    output      logic                irq_o,          // Level interrupt
    // Decoded bus side
    input  wire logic                tok_valid_i,    // Token strobe
    input  wire uea_pkg::uea_tok_t   tok_kind_i,     // Token kind
    input  wire logic [6:0]          tok_addr_i,     // Token address
    input  wire logic [3:0]          tok_ep_i,       // Token endpoint
    input  wire logic                data_valid_i,   // Data byte strobe
    input  wire logic [7:0]          data_byte_i,    // Data byte
    input  wire logic                data_pid_i,     // Data packet PID, 1 = DATA1
    input  wire logic                pkt_end_i,      // End of data packet
    input  wire logic                pkt_ok_i,       // Packet CRC good
    output      logic                hs_valid_o,     // Handshake strobe
    output      uea_pkg::uea_hs_t    hs_code_o,      // Handshake to send
    output      logic                in_force_nak_o, // Endpoint 0 IN must NAK
    // Buffer manager write port
    output      logic                buf_we_o,       // Buffer write strobe
    output      logic [2:0]          buf_addr_o,     // Buffer byte index
    output      logic [7:0]          buf_data_o,     // Buffer byte
    output      logic                buf_setup_o     // Byte belongs to setup buffer
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        uea_pkg::uea_state_t        fsm;
        logic                       kind_setup;
        logic                       accept;
        logic                       permit;
        logic                       stall;
        logic                       ie;
        logic                       toggle;
        logic                       nak;
        logic [3:0]                 count;
        logic [6:0]                 addr;
        logic [uea_pkg::EVT_WIDTH-1:0] status;
        logic [uea_pkg::EVT_WIDTH-1:0] mask;
        logic [DATA_W-1:0]          rdata;
        logic                       hs_valid;
        uea_pkg::uea_hs_t           hs_code;
        logic                       buf_we;
        logic [2:0]                 buf_addr;
        logic [7:0]                 buf_data;
        logic                       buf_setup;
    } uea_state_t;

    localparam uea_state_t RST_STATE = '{
        fsm:        uea_pkg::ST_IDLE,
        kind_setup: 1'b0,
        accept:     1'b0,
        permit:     1'b0,
        stall:      1'b0,
        ie:         1'b0,
        toggle:     uea_pkg::RST_TOGGLE,
        nak:        uea_pkg::RST_NAK,
        count:      4'h0,
        addr:       uea_pkg::RST_ADDRESS,
        status:     '0,
        mask:       '0,
        rdata:      '0,
        hs_valid:   1'b0,
        hs_code:    uea_pkg::HS_NONE,
        buf_we:     1'b0,
        buf_addr:   3'h0,
        buf_data:   8'h00,
        buf_setup:  1'b0
    };

    uea_state_t q;
    uea_state_t d;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    logic       tok_hit;
    logic [3:0] rx_count;
    logic       rx_full;
    logic       cnt_clear;
    logic       cnt_inc;
    logic       setup_flag;

    assign setup_flag = q.status[uea_pkg::EVT_SETUP];

    uea_addr_match #(
        .ADDR_W (7)
    ) u_match (
        .tok_valid_i (tok_valid_i),
        .tok_addr_i  (tok_addr_i),
        .tok_ep_i    (tok_ep_i),
        .own_addr_i  (q.addr),
        .hit_o       (tok_hit)
    );

    uea_byte_counter #(
        .MAX_BYTES (uea_pkg::EP0_MAX_BYTES)
    ) u_count (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .clear_i (cnt_clear),
        .inc_i   (cnt_inc),
        .count_o (rx_count),
        .full_o  (rx_full)
    );

    assign cnt_clear = (q.fsm == uea_pkg::ST_IDLE) && tok_hit;
    assign cnt_inc   = (q.fsm == uea_pkg::ST_DATA) && data_valid_i && q.accept && !rx_full;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d          = q;
        d.hs_valid = 1'b0;
        d.buf_we   = 1'b0;
        d.rdata    = '0;

        // Register writes
        if (reg_we_i)
        begin
            case (reg_addr_i)
                uea_pkg::OFS_OUT_EP0_CONFIG:
                begin
                    d.permit = reg_wdata_i[uea_pkg::CFG_PERMIT_BIT];
                    d.stall  = reg_wdata_i[uea_pkg::CFG_STALL_BIT];
                    d.ie     = reg_wdata_i[uea_pkg::CFG_IE_BIT];
                end
                uea_pkg::OFS_OUT_EP0_BYTE_COUNT:
                begin
                    d.nak = reg_wdata_i[uea_pkg::CNT_NAK_BIT];
                end
                uea_pkg::OFS_FUNCTION_ADDRESS:
                begin
                    d.addr = reg_wdata_i[6:0];
                end
                uea_pkg::OFS_EVENT_STATUS:
                begin
                    d.status = q.status & ~reg_wdata_i[uea_pkg::EVT_WIDTH-1:0];
                end
                uea_pkg::OFS_EVENT_MASK:
                begin
                    d.mask = reg_wdata_i[uea_pkg::EVT_WIDTH-1:0];
                end
                default:
                begin
                end
            endcase
        end

        // Register reads, answered next cycle
        if (reg_re_i)
        begin
            case (reg_addr_i)
                uea_pkg::OFS_OUT_EP0_CONFIG:
                begin
                    d.rdata[uea_pkg::CFG_PERMIT_BIT] = q.permit;
                    d.rdata[uea_pkg::CFG_TOGGLE_BIT] = q.toggle;
                    d.rdata[uea_pkg::CFG_STALL_BIT]  = q.stall;
                    d.rdata[uea_pkg::CFG_IE_BIT]     = q.ie;
                end
                uea_pkg::OFS_OUT_EP0_BYTE_COUNT:
                begin
                    d.rdata[uea_pkg::CNT_NAK_BIT] = q.nak;
                    d.rdata[3:0]                  = q.count;
                end
                uea_pkg::OFS_FUNCTION_ADDRESS:
                begin
                    d.rdata[6:0] = q.addr;
                end
                uea_pkg::OFS_EVENT_STATUS:
                begin
                    d.rdata[uea_pkg::EVT_WIDTH-1:0] = q.status;
                end
                uea_pkg::OFS_EVENT_MASK:
                begin
                    d.rdata[uea_pkg::EVT_WIDTH-1:0] = q.mask;
                end
                default:
                begin
                end
            endcase
        end

        // Transaction handling
        case (q.fsm)
            uea_pkg::ST_IDLE:
            begin
                if (tok_hit && (tok_kind_i == uea_pkg::TOK_SETUP))
                begin
                    d.kind_setup = 1'b1;
                    d.accept     = 1'b1;
                    d.fsm        = uea_pkg::ST_DATA;
                end
                else if (tok_hit && (tok_kind_i == uea_pkg::TOK_OUT))
                begin
                    d.kind_setup = 1'b0;
                    d.accept     = q.permit && !q.stall && !q.nak && !setup_flag;
                    d.fsm        = uea_pkg::ST_DATA;
                end
            end
            uea_pkg::ST_DATA:
            begin
                if (cnt_inc)
                begin
                    d.buf_we    = 1'b1;
                    d.buf_addr  = rx_count[2:0];
                    d.buf_data  = data_byte_i;
                    d.buf_setup = q.kind_setup;
                end
                if (pkt_end_i)
                begin
                    d.fsm = uea_pkg::ST_IDLE;
                    if (pkt_ok_i && q.kind_setup)
                    begin
                        d.hs_valid = 1'b1;
                        d.hs_code  = uea_pkg::HS_ACK;
                        d.stall    = 1'b0;
                        d.toggle   = 1'b1;
                        d.status[uea_pkg::EVT_SETUP] = 1'b1;
                    end
                    else if (pkt_ok_i && q.stall)
                    begin
                        d.hs_valid = 1'b1;
                        d.hs_code  = uea_pkg::HS_STALL;
                        d.status[uea_pkg::EVT_STALL_SENT] = 1'b1;
                    end
                    else if (pkt_ok_i && !q.accept)
                    begin
                        d.hs_valid = 1'b1;
                        d.hs_code  = uea_pkg::HS_NAK;
                    end
                    else if (pkt_ok_i)
                    begin
                        d.hs_valid = 1'b1;
                        d.hs_code  = uea_pkg::HS_ACK;
                        // Repeated packet is acknowledged but not committed
                        if (data_pid_i == q.toggle)
                        begin
                            d.count  = rx_count;
                            d.nak    = 1'b1;
                            d.toggle = ~q.toggle;
                            if (q.ie)
                            begin
                                d.status[uea_pkg::EVT_OUT_DONE] = 1'b1;
                            end
                        end
                    end
                end
                else if (tok_valid_i)
                begin
                    // Token without data ends the transaction silently
                    d.fsm = uea_pkg::ST_IDLE;
                end
            end
            default:
            begin
                d.fsm = uea_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= RST_STATE;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o    = q.rdata;
    assign irq_o          = |(q.status & q.mask);
    assign hs_valid_o     = q.hs_valid;
    assign hs_code_o      = q.hs_code;
    assign in_force_nak_o = setup_flag;
    assign buf_we_o       = q.buf_we;
    assign buf_addr_o     = q.buf_addr;
    assign buf_data_o     = q.buf_data;
    assign buf_setup_o    = q.buf_setup;

endmodule : uea_ep0_out

// [uea_ep0_out_assertions.sv]
// Checker for the control endpoint output and address block
`timescale 1ns/1ns
module uea_ep0_out_assertions (
    input wire logic             clk_i,          // Core clock
    input wire logic             arst_n_i,       // Reset, low active
    input wire logic [15:0]      reg_addr_i,     // Register address
    input wire logic [7:0]       reg_wdata_i,    // Write data
    input wire logic             reg_we_i,       // Write strobe
    input wire logic             reg_re_i,       // Read strobe
    input wire logic [7:0]       reg_rdata_o,    // Read data
    input wire logic             data_valid_i,   // Byte strobe
    input wire logic [7:0]       data_byte_i,    // Data byte
    input wire logic             pkt_end_i,      // End of packet
    input wire logic             pkt_ok_i,       // CRC good
    input wire logic             hs_valid_o,     // Handshake strobe
    input wire uea_pkg::uea_hs_t hs_code_o,      // Handshake code
    input wire logic             in_force_nak_o, // Setup flag
    input wire logic             buf_we_o,       // Buffer strobe
    input wire logic [7:0]       buf_data_o      // Buffer byte
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    sequence s_addr_wr;
        reg_we_i && reg_addr_i == 16'hFFFF;
    endsequence
    sequence s_addr_rd;
        reg_re_i && reg_addr_i == 16'hFFFF;
    endsequence

    rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read cycle");
    addr_readback_a: assert property (s_addr_wr ##2 s_addr_rd |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h7F))
        else $error("address readback wrong");
    count_code_a: assert property (reg_re_i && reg_addr_i == 16'hFF83 |=> reg_rdata_o[6:4] == 3'h0 && reg_rdata_o[3:0] <= 4'h8)
        else $error("byte count code out of range");
    cfg_reserved_a: assert property (reg_re_i && reg_addr_i == 16'hFF82 |=> (reg_rdata_o & 8'h53) == 8'h00)
        else $error("config reserved bits set");

    // ----------------------------------------
    // Transaction side
    // ----------------------------------------
    hs_timing_a: assert property (hs_valid_o |-> $past(pkt_end_i) && $past(pkt_ok_i) && hs_code_o != uea_pkg::HS_NONE)
        else $error("handshake without good packet end");
    bad_crc_quiet_a: assert property (pkt_end_i && !pkt_ok_i |=> !hs_valid_o)
        else $error("handshake after bad packet");
    buf_timing_a: assert property (buf_we_o |-> $past(data_valid_i) && buf_data_o == $past(data_byte_i))
        else $error("buffer write without byte");
    setup_rise_a: assert property ($rose(in_force_nak_o) |-> hs_valid_o && hs_code_o == uea_pkg::HS_ACK)
        else $error("setup flag rose without setup ack");
    setup_fall_a: assert property ($fell(in_force_nak_o) |-> $past(reg_we_i) && $past(reg_addr_i) == 16'hFF84)
        else $error("setup flag fell without clear");
endmodule : uea_ep0_out_assertions

bind uea_ep0_out uea_ep0_out_assertions uea_ep0_out_assertions_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .data_valid_i(data_valid_i), .data_byte_i(data_byte_i),
    .pkt_end_i(pkt_end_i), .pkt_ok_i(pkt_ok_i), .hs_valid_o(hs_valid_o), .hs_code_o(hs_code_o),
    .in_force_nak_o(in_force_nak_o), .buf_we_o(buf_we_o), .buf_data_o(buf_data_o));

// [uea_host_model.sv]
// Host side model sending tokens and data packets
`timescale 1ns/1ns
module uea_host_model (
    input  wire logic              clk_i,        // Core clock
    input  wire logic              hs_valid_i,   // Handshake strobe
    input  wire uea_pkg::uea_hs_t  hs_code_i,    // Handshake code
    output      logic              tok_valid_o,  // Token strobe
    output      uea_pkg::uea_tok_t tok_kind_o,   // Token kind
    output      logic [6:0]        tok_addr_o,   // Token address
    output      logic [3:0]        tok_ep_o,     // Token endpoint
    output      logic              data_valid_o, // Byte strobe
    output      logic [7:0]        data_byte_o,  // Data byte
    output      logic              data_pid_o,   // 1 = DATA1
    output      logic              pkt_end_o,    // End of packet
    output      logic              pkt_ok_o      // CRC good
);
    initial
    begin
        {tok_valid_o, data_valid_o, pkt_end_o, pkt_ok_o, data_pid_o} = 5'h00;
        tok_kind_o = uea_pkg::TOK_OUT;
        {tok_addr_o, tok_ep_o, data_byte_o} = 19'h00000;
    end

    // Token, n bytes, packet end except for IN; handshake seen one cycle on
    task automatic xfer(input uea_pkg::uea_tok_t k, input logic [6:0] a, input int n,
                        input logic p, input logic ok, output logic v, output uea_pkg::uea_hs_t c);
        tok_valid_o <= 1'b1;
        tok_kind_o  <= k;
        tok_addr_o  <= a;
        tok_ep_o    <= 4'h0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            tok_valid_o  <= 1'b0;
            data_valid_o <= 1'b1;
            data_byte_o  <= 8'(8'hA0 + i);
        end
        @(posedge clk_i);
        tok_valid_o  <= 1'b0;
        data_valid_o <= 1'b0;
        // Released lines show no stale value
        data_byte_o  <= ~data_byte_o;
        tok_addr_o   <= ~a;
        if (k != uea_pkg::TOK_IN)
        begin
            pkt_end_o  <= 1'b1;
            pkt_ok_o   <= ok;
            data_pid_o <= p;
            @(posedge clk_i);
            pkt_end_o  <= 1'b0;
            pkt_ok_o   <= ~ok;
        end
        @(negedge clk_i);
        v = hs_valid_i;
        c = hs_code_i;
        @(posedge clk_i);
    endtask : xfer
endmodule : uea_host_model

// [uea_pkg.sv]
// Shared constants and types for the control endpoint output and address block
package uea_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] OFS_OUT_EP0_CONFIG     = 16'hFF82;
    localparam logic [15:0] OFS_OUT_EP0_BYTE_COUNT = 16'hFF83;
    localparam logic [15:0] OFS_EVENT_STATUS       = 16'hFF84;
    localparam logic [15:0] OFS_EVENT_MASK         = 16'hFF85;
    localparam logic [15:0] OFS_FUNCTION_ADDRESS   = 16'hFFFF;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_PERMIT_BIT = 7;
    localparam int CFG_TOGGLE_BIT = 5;
    localparam int CFG_STALL_BIT  = 3;
    localparam int CFG_IE_BIT     = 2;
    localparam int CNT_NAK_BIT    = 7;
    localparam int EVT_OUT_DONE   = 0;
    localparam int EVT_SETUP      = 1;
    localparam int EVT_STALL_SENT = 2;
    localparam int EVT_WIDTH      = 3;

    // ------------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------------
    localparam logic       RST_NAK     = 1'b1;
    localparam logic       RST_TOGGLE  = 1'b0;
    localparam logic [6:0] RST_ADDRESS = 7'h00;
    localparam int         EP0_MAX_BYTES = 8;
    localparam logic [3:0] EP0_ENDPOINT  = 4'h0;

    // ------------------------------------------------------------------
    // Token kinds, handshakes, states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TOK_OUT   = 2'h0,
        TOK_IN    = 2'h1,
        TOK_SETUP = 2'h2
    } uea_tok_t;

    typedef enum logic [1:0] {
        HS_NONE  = 2'h0,
        HS_ACK   = 2'h1,
        HS_NAK   = 2'h2,
        HS_STALL = 2'h3
    } uea_hs_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_DATA = 1'b1
    } uea_state_t;

endpackage : uea_pkg
